/* hw/rpsm_top.sv */
// rpsm_top: repeater port statistics and management registers
// assumes pin-level activity inputs are asynchronous; management port on clock
//
// Notes on behaviour
// - self-test leaves state alone, then health notice
// - health notice on health change, not power-up
// - reset notice at power-up and reset action end
// - group presence notice on group map change
// - group identifier and port limit within 1..1024
// - port presence bits, one per port, 1 present
// - port presence notice on port map change
// - enable state 1 disabled 2 enabled, overrides isolation
// - isolation state reads 1 partitioned, 2 not
// - enable action restarts isolation machine at begin
// - repeater-wide 32-bit transmit collision counter
// - count good frames 64..1518 bytes, crc ok
// - add good frame length to octet total
// - count crc errors without framing error
// - count crc plus framing errors separately
// - count frames over 1518 bytes
// - count bursts shorter than brief activity limit
// - count bursts between limit and 512 bits
// - count collisions while carrier present
// - count late collisions, also ordinary collisions
// - count transmitter active past jabber limit
// - count incoming rate mismatches
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module rpsm_top
  import rpsm_pkg::*;
#(
  parameter logic [CW-1:0] GROUP_ID    = 32'h0000_0001,
  parameter logic [CW-1:0] GROUP_LIMIT = 32'h0000_0004
) (
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  input  wire logic [AW-1:0]              addr,
  input  wire logic [CW-1:0]              wrData,
  input  wire logic                       wrStrobe,
  input  wire logic                       rdStrobe,
  output logic      [CW-1:0]              rdData,
  input  wire logic [rpsm_pkg::NPORTS-1:0] carrierPin,
  input  wire logic [rpsm_pkg::NPORTS-1:0] collisionPin,
  input  wire logic [rpsm_pkg::NPORTS-1:0] txActivePin,
  input  wire logic [rpsm_pkg::NPORTS-1:0] rateMismatchPin,
  input  wire logic [rpsm_pkg::NPORTS-1:0] partitionedPin,
  input  wire logic [rpsm_pkg::NPORTS-1:0] portPresentPin,
  input  wire logic                       groupPresentPin,
  input  wire logic                       repeaterTxColl,
  input  wire logic [rpsm_pkg::NPORTS-1:0] frameEnd,
  input  wire logic [rpsm_pkg::NPORTS-1:0] crcOk,
  input  wire logic [rpsm_pkg::NPORTS-1:0] framingErr,
  input  wire logic [10:0]                frameLen,
  input  wire logic [CW-1:0]              healthIn,
  input  wire logic [rpsm_pkg::NPORTS-1:0] enableStore,
  output logic      [rpsm_pkg::NPORTS-1:0] portEnable,
  output logic      [rpsm_pkg::NPORTS-1:0] isolationRestart,
  output logic                            noticeValid,
  output logic      [2:0]                 noticeKind,
  output logic      [CW-1:0]              noticeData
);
  // two-stage synchronisers for pin inputs
  localparam int NSYNC = 6 * NPORTS + 2;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {repeaterTxColl, groupPresentPin, portPresentPin, partitionedPin,
                  rateMismatchPin, txActivePin, collisionPin, carrierPin};
      sync2_q <= sync1_q;
    end
  end
  logic [NPORTS-1:0] carS, colS, txS, rateS, partS, presS;
  logic              grpS, txCollS;
  assign {txCollS, grpS, presS, partS, rateS, txS, colS, carS} = sync2_q;

  logic [NPORTS-1:0] enable_q;
  logic [NPORTS-1:0] restart_q;
  logic [CW-1:0]     txColl_q;
  logic              txCollPrev_q;
  logic [CW-1:0]     cnt_q [NPORTS][NCNT];
  logic [CW-1:0]     rdData_q;
  logic              initDone_q;
  logic [NPORTS-1:0] port_presence_bits_q;
  logic              groupMap_q;
  logic [CW-1:0]     health_q;
  logic              noticeValid_q;
  rpsm_note_e        noticeKind_q;
  logic [CW-1:0]     noticeData_q;
  rpsm_test_e        test_q;
  logic              resetAct_q;
  logic [1:0]        settle_q;
  wire logic [NPORTS-1:0][NCNT-1:0] incAll;
  wire logic [NPORTS-1:0][10:0]     octAll;

  logic       wrAction;
  logic [3:0] actPort;
  assign wrAction = wrStrobe && addr == A_ACTION;
  assign actPort  = wrData[11:8];

  // enable state persists: it loads from the external store in the first cycle after reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      enable_q  <= '0;
      restart_q <= '0;
    end else begin
      restart_q <= '0;
      if (!initDone_q)
        enable_q <= enableStore;
      else if (wrAction && wrData[3:0] == ACT_PORTCTL && 32'(actPort) < NPORTS) begin
        enable_q[actPort[1:0]] <= wrData[16];
        if (wrData[16] && !enable_q[actPort[1:0]])
          restart_q[actPort[1:0]] <= 1'b1;
      end
    end
  end

  // per-port monitors and counters
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    rpsm_evt_if evt ();
    rpsm_port_mon u_mon (
      .clock        (clock),
      .reset_n      (reset_n),
      .enabled      (enable_q[p]),
      .carrier      (carS[p]),
      .collision    (colS[p]),
      .txActive     (txS[p]),
      .rateMismatch (rateS[p]),
      .frameEnd     (frameEnd[p]),
      .crcOk        (crcOk[p]),
      .framingErr   (framingErr[p]),
      .frameLen     (frameLen),
      .evt          (evt.mon)
    );
    assign incAll[p] = evt.inc;
    assign octAll[p] = evt.octets;
  end

  // one process owns the whole counter array, so no element has two writers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int p = 0; p < NPORTS; p++)
        for (int c = 0; c < NCNT; c++)
          cnt_q[p][c] <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++)
        for (int c = 0; c < NCNT; c++)
          if (incAll[p][c])
            cnt_q[p][c] <= (c == C_OCTET) ? cnt_q[p][c] + CW'(octAll[p])
                                          : cnt_q[p][c] + 1'b1;
    end
  end

  // repeater-wide transmit collisions
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      txColl_q     <= '0;
      txCollPrev_q <= 1'b0;
    end else begin
      txCollPrev_q <= txCollS;
      if (txCollS && !txCollPrev_q)
        txColl_q <= txColl_q + 1'b1;
    end
  end

  // self-test: only observes, so forwarding and counters are untouched
  always_ff @(posedge clock) begin
    if (!reset_n)
      test_q <= ST_IDLE;
    else begin
      case (test_q)
        ST_IDLE: if (wrAction && wrData[3:0] == ACT_SELFTEST) test_q <= ST_TEST;
        ST_TEST: test_q <= ST_DONE;
        ST_DONE: test_q <= ST_IDLE;
        default: test_q <= ST_IDLE;
      endcase
    end
  end

  // notices; map changes are ignored until settle_q reaches 3 so power-up changes stay quiet
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      initDone_q    <= 1'b0;
      port_presence_bits_q     <= '0;
      groupMap_q    <= 1'b0;
      health_q      <= HEALTH_OK;
      noticeValid_q <= 1'b0;
      noticeKind_q  <= NOTE_NONE;
      noticeData_q  <= '0;
      resetAct_q    <= 1'b0;
      settle_q      <= '0;
    end else begin
      noticeValid_q <= 1'b0;
      port_presence_bits_q     <= presS;
      groupMap_q    <= grpS;
      health_q      <= healthIn;
      resetAct_q    <= wrAction && wrData[3:0] == ACT_RESET;
      // maps fill through the synchroniser first; changes before that are power-up noise
      if (settle_q != '1)
        settle_q <= settle_q + 1'b1;
      if (!initDone_q) begin
        initDone_q    <= 1'b1;
        noticeValid_q <= 1'b1;
        noticeKind_q  <= NOTE_RESET;
        noticeData_q  <= healthIn;
      end else if (resetAct_q) begin
        noticeValid_q <= 1'b1;
        noticeKind_q  <= NOTE_RESET;
        noticeData_q  <= healthIn;
      end else if (healthIn != health_q || test_q == ST_DONE) begin
        noticeValid_q <= 1'b1;
        noticeKind_q  <= NOTE_HEALTH;
        noticeData_q  <= healthIn;
      end else if (settle_q == '1 && grpS != groupMap_q) begin
        noticeValid_q <= 1'b1;
        noticeKind_q  <= NOTE_GROUP;
        noticeData_q  <= CW'(grpS);
      end else if (settle_q == '1 && presS != port_presence_bits_q) begin
        noticeValid_q <= 1'b1;
        noticeKind_q  <= NOTE_PORT;
        noticeData_q  <= CW'(presS);
      end
    end
  end

  // register read, data one cycle later
  always_ff @(posedge clock) begin
    if (!reset_n)
      rdData_q <= '0;
    else if (rdStrobe) begin
      rdData_q <= '0;
      if (addr < AW'(NPORTS * 16)) begin
        if (addr[3:0] < 4'(NCNT))
          rdData_q <= cnt_q[addr[5:4]][addr[3:0]];
        else if (addr[3:0] == I_ENABLE)
          rdData_q <= enable_q[addr[5:4]] ? ADMIN_ENABLED : ADMIN_DISABLED;
        else if (addr[3:0] == I_ISOLATION)
          rdData_q <= (partS[addr[5:4]] && enable_q[addr[5:4]]) ? PART_YES : PART_NO;
      end else begin
        case (addr)
          A_TXCOLL:    rdData_q <= txColl_q;
          A_GROUP_IDENTIFIER:   rdData_q <= GROUP_ID;
          A_PORTLIMIT: rdData_q <= GROUP_LIMIT;
          A_PORT_PRESENCE_BITS:   rdData_q <= CW'(port_presence_bits_q);
          A_GROUPMAP:  rdData_q <= CW'(groupMap_q);
          A_HEALTH:    rdData_q <= health_q;
          default:     rdData_q <= '0;
        endcase
      end
    end
  end

  assign rdData           = rdData_q;
  assign portEnable       = enable_q;
  assign isolationRestart = restart_q;
  assign noticeValid      = noticeValid_q;
  assign noticeKind       = noticeKind_q;
  assign noticeData       = noticeData_q;

  chk_restart_on_enable: assert property (@(posedge clock) disable iff (!reset_n)
    restart_q != '0 |-> (restart_q & ~(enable_q & ~$past(enable_q))) == '0)
    else $error("restart without enable edge");
  chk_selftest_notice: assert property (@(posedge clock) disable iff (!reset_n)
    test_q == ST_TEST ##1 test_q == ST_DONE |-> ##1 noticeValid_q)
    else $error("self-test ended with no notice");
  chk_powerup_reset: assert property (@(posedge clock)
    $rose(reset_n) |-> ##1 noticeValid_q && noticeKind_q == NOTE_RESET) else $error("no reset notice");
  chk_txcoll_wrap: assert property (@(posedge clock) disable iff (!reset_n)
    txCollS && !txCollPrev_q |=> txColl_q == $past(txColl_q) + 32'h0000_0001)
    else $error("counter did not step by one");
endmodule : rpsm_top
`default_nettype wire

/* hw/rpsm_pkg.sv */
// rpsm_pkg: constants and types shared by the repeater port statistics block
// assumes a 125 MHz clock and 10 Mb/s ports (one bit time is 100 ns)
package rpsm_pkg;
  localparam int NPORTS = 4;
  localparam int CW     = 32;
  localparam int AW     = 8;

  // timing figures as printed, converted to clock cycles (8 ns clock)
  localparam int CLK_PERIOD_PS       = 8000;
  localparam int BIT_TIME_PS         = 100000;
  localparam int BRIEF_LIMIT_BITS    = 78;   // inside the 74..82 window
  localparam int MIN_FRAME_BITS      = 512;
  localparam int LATE_THRESH_BITS    = 512;  // inside the 480..565 window
  localparam int JABBER_LIMIT_US     = 5000; // inside 4 ms..7.5 ms
  localparam int BRIEF_LIMIT_CYC     = (BRIEF_LIMIT_BITS * BIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIN_FRAME_CYC       = (MIN_FRAME_BITS * BIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LATE_THRESH_CYC     = (LATE_THRESH_BITS * BIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // scaled in two steps: the product in picoseconds would not fit an int
  localparam int JABBER_LIMIT_CYC    = (JABBER_LIMIT_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int MIN_FRAME_BYTES     = 64;
  localparam int MAX_FRAME_BYTES     = 1518;
  localparam int TW                  = 20;

  // per-port counter indices
  localparam int NCNT = 11;
  localparam logic [3:0] C_GOOD = 4'h0, C_OCTET = 4'h1, C_CRC = 4'h2, C_ALIGN = 4'h3, C_OVER = 4'h4,
                         C_BRIEF = 4'h5, C_RUNT = 4'h6, C_COLL = 4'h7, C_LATE = 4'h8, C_JAB = 4'h9,
                         C_RATE = 4'ha;

  // register map: address = {port[3:0], index[3:0]} for counters
  localparam logic [AW-1:0] A_PORT_BASE  = 8'h00;   // ports at 0x00..0x3f
  localparam logic [3:0]    I_ENABLE     = 4'hb;    // port_enable_state (1 dis, 2 en)
  localparam logic [3:0]    I_ISOLATION  = 4'hc;    // isolation_state (1 part, 2 not)
  localparam logic [AW-1:0] A_TXCOLL     = 8'h80;
  localparam logic [AW-1:0] A_GROUP_IDENTIFIER    = 8'h81;
  localparam logic [AW-1:0] A_PORTLIMIT  = 8'h82;
  localparam logic [AW-1:0] A_PORT_PRESENCE_BITS    = 8'h83;
  localparam logic [AW-1:0] A_GROUPMAP   = 8'h84;
  localparam logic [AW-1:0] A_HEALTH     = 8'h85;
  localparam logic [AW-1:0] A_ACTION     = 8'h86;   // write: action code
  localparam logic [AW-1:0] A_NOTICE     = 8'h87;   // not decoded by the read logic: reads return 0

  localparam logic [CW-1:0] ADMIN_DISABLED = 32'h0000_0001;
  localparam logic [CW-1:0] ADMIN_ENABLED  = 32'h0000_0002;
  localparam logic [CW-1:0] PART_YES       = 32'h0000_0001;
  localparam logic [CW-1:0] PART_NO        = 32'h0000_0002;
  localparam logic [CW-1:0] HEALTH_OK      = 32'h0000_0002;

  // action codes in write data [3:0]; port number in [11:8], enable bit in [16]
  localparam logic [3:0] ACT_SELFTEST = 4'h1;
  localparam logic [3:0] ACT_PORTCTL  = 4'h2;
  localparam logic [3:0] ACT_RESET    = 4'h3;

  typedef enum logic [2:0] {
    NOTE_NONE, NOTE_HEALTH, NOTE_RESET, NOTE_GROUP, NOTE_PORT
  } rpsm_note_e;

  typedef enum {ST_IDLE, ST_TEST, ST_DONE} rpsm_test_e;
endpackage : rpsm_pkg

/* hw/rpsm_evt_if.sv */
// rpsm_evt_if: event strobes from one port monitor to the counter file
// assumes single clock domain; strobes are one cycle long
`timescale 1ns/10ps
`default_nettype none
interface rpsm_evt_if;
  logic [rpsm_pkg::NCNT-1:0] inc;
  logic [10:0]               octets;
  modport mon (output inc, output octets);
  modport cnt (input inc, input octets);
endinterface : rpsm_evt_if
`default_nettype wire

/* hw/rpsm_port_mon.sv */
// rpsm_port_mon: classifies carrier activity on one port into event strobes
// assumes inputs already synchronised to clock
`timescale 1ns/10ps
`default_nettype none
module rpsm_port_mon
  import rpsm_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   reset_n,
  input  wire logic   enabled,
  input  wire logic   carrier,
  input  wire logic   collision,
  input  wire logic   txActive,
  input  wire logic   rateMismatch,
  input  wire logic   frameEnd,
  input  wire logic   crcOk,
  input  wire logic   framingErr,
  input  wire logic   [10:0] frameLen,
  rpsm_evt_if.mon     evt
);
  logic [TW-1:0] actCnt_q;
  logic [TW-1:0] txCnt_q;
  logic          carrier_q;
  logic          collSeen_q;
  logic          collPrev_q;
  logic          rateSeen_q;
  logic          jabDone_q;
  logic          endAct;
  logic          collEdge;
  logic          lenOk;
  logic          goodFrame;

  assign endAct    = carrier_q && !carrier;
  assign collEdge  = collision && !collPrev_q && carrier && enabled;
  assign lenOk     = frameLen >= 11'(MIN_FRAME_BYTES) && frameLen <= 11'(MAX_FRAME_BYTES);
  assign goodFrame = frameEnd && enabled && lenOk && crcOk && !collSeen_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      actCnt_q   <= '0;
      carrier_q  <= 1'b0;
      collSeen_q <= 1'b0;
      collPrev_q <= 1'b0;
    end else begin
      carrier_q  <= carrier && enabled;
      collPrev_q <= collision;
      if (carrier && enabled)
        actCnt_q <= (actCnt_q == '1) ? actCnt_q : actCnt_q + 1'b1;
      else
        actCnt_q <= '0;
      if (!carrier_q)
        collSeen_q <= 1'b0;
      if (collEdge)
        collSeen_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      txCnt_q   <= '0;
      jabDone_q <= 1'b0;
      rateSeen_q <= 1'b0;
    end else begin
      rateSeen_q <= rateMismatch;
      if (txActive && enabled)
        txCnt_q <= (txCnt_q == '1) ? txCnt_q : txCnt_q + 1'b1;
      else
        txCnt_q <= '0;
      if (!txActive)
        jabDone_q <= 1'b0;
      else if (txCnt_q == TW'(JABBER_LIMIT_CYC))
        jabDone_q <= 1'b1;
    end
  end

  always_comb begin
    evt.inc = '0;
    evt.inc[C_GOOD]  = goodFrame;
    evt.inc[C_OCTET] = goodFrame;
    evt.inc[C_CRC]   = frameEnd && enabled && lenOk && !crcOk && !framingErr && !collSeen_q;
    evt.inc[C_ALIGN] = frameEnd && enabled && !crcOk && framingErr;
    evt.inc[C_OVER]  = frameEnd && enabled && frameLen > 11'(MAX_FRAME_BYTES);
    evt.inc[C_BRIEF] = endAct && actCnt_q < TW'(BRIEF_LIMIT_CYC);
    evt.inc[C_RUNT]  = endAct && actCnt_q >= TW'(BRIEF_LIMIT_CYC)
                       && actCnt_q < TW'(MIN_FRAME_CYC);
    evt.inc[C_COLL]  = collEdge;
    evt.inc[C_LATE]  = collEdge && actCnt_q >= TW'(LATE_THRESH_CYC);
    evt.inc[C_JAB]   = txActive && enabled && !jabDone_q
                       && txCnt_q == TW'(JABBER_LIMIT_CYC);
    evt.inc[C_RATE]  = rateMismatch && !rateSeen_q && enabled;
    evt.octets       = frameLen;
  end

  chk_late_implies_coll: assert property (@(posedge clock) disable iff (!reset_n)
    evt.inc[C_LATE] |-> evt.inc[C_COLL]) else $error("late collision without collision");
  chk_crc_align_excl: assert property (@(posedge clock) disable iff (!reset_n)
    !(evt.inc[C_CRC] && evt.inc[C_ALIGN])) else $error("crc and alignment both counted");
  chk_good_octet_pair: assert property (@(posedge clock) disable iff (!reset_n)
    evt.inc[C_GOOD] == evt.inc[C_OCTET]) else $error("octets added off a good frame");
  chk_brief_runt_excl: assert property (@(posedge clock) disable iff (!reset_n)
    !(evt.inc[C_BRIEF] && evt.inc[C_RUNT])) else $error("burst counted twice");
  chk_jabber_once: assert property (@(posedge clock) disable iff (!reset_n)
    evt.inc[C_JAB] |=> !evt.inc[C_JAB]) else $error("jabber counted twice");
endmodule : rpsm_port_mon
`default_nettype wire

/* verification/rpsm_agent.sv */
// rpsm_agent: management agent model on the register port
// assumes read data stand from the cycle after the strobe until the next read strobe
`timescale 1ns/10ps
`default_nettype none
module rpsm_agent
  import rpsm_pkg::*;
(
  input  wire logic                   clock,
  output logic      [rpsm_pkg::AW-1:0] addr,
  output logic      [rpsm_pkg::CW-1:0] wrData,
  output logic                        wrStrobe,
  output logic                        rdStrobe,
  input  wire logic [rpsm_pkg::CW-1:0] rdData
);
  initial begin
    addr     = '0;
    wrData   = '0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
  end
  // released lines show the inverse so stale values never pass
  task automatic wr(input logic [AW-1:0] a, input logic [CW-1:0] d);
    @(posedge clock);
    addr     <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
    addr     <= ~a;
    wrData   <= ~d;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, output logic [CW-1:0] d);
    @(posedge clock);
    addr     <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    addr     <= ~a;
    #1;
    d = rdData;
  endtask : rd
  // enable bit 1 enables, 0 disables
  task automatic portCtl(input int p, input logic en);
    wr(A_ACTION, {15'h0, en, 4'h0, p[3:0], 4'h0, ACT_PORTCTL});
  endtask : portCtl
endmodule : rpsm_agent
`default_nettype wire

/* verification/tb_top.sv */
// tb_top: self-checking bench for the repeater port statistics block
// assumes rpsm_agent as manager; pins driven on rising edges
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rpsm_pkg::*;
  logic clock, reset_n, wrStrobe, rdStrobe, groupPresentPin, repeaterTxColl, noticeValid;
  logic [AW-1:0] addr;
  logic [CW-1:0] wrData, rdData, healthIn, noticeData;
  logic [NPORTS-1:0] carrierPin, collisionPin, txActivePin, rateMismatchPin, partitionedPin, portPresentPin;
  logic [NPORTS-1:0] frameEnd, crcOk, framingErr, enableStore, portEnable, isolationRestart;
  logic [10:0] frameLen;
  logic [2:0] noticeKind;
  logic [CW-1:0] expCnt [NPORTS][NCNT];
  logic [2:0] nk [$];
  logic [CW-1:0] nd [$];
  int err_total, samples_checked, cyc;
  rpsm_agent u_agent (.clock, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData);
  rpsm_top #(.GROUP_ID(32'h0000_0003), .GROUP_LIMIT(32'h0000_0004)) u_dut (
    .clock, .reset_n, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .carrierPin, .collisionPin,
    .txActivePin, .rateMismatchPin, .partitionedPin, .portPresentPin, .groupPresentPin, .repeaterTxColl,
    .frameEnd, .crcOk, .framingErr, .frameLen, .healthIn, .enableStore, .portEnable, .isolationRestart,
    .noticeValid, .noticeKind, .noticeData);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (noticeValid === 1'b1) begin
      nk.push_back(noticeKind);
      nd.push_back(noticeData);
    end
    if (cyc == 40000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [CW-1:0] e, input logic [CW-1:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdChk(input string nm, input logic [AW-1:0] a, input logic [CW-1:0] e);
    logic [CW-1:0] g;
    u_agent.rd(a, g);
    chk(nm, e, g);
  endtask : rdChk
  // exactly one notice expected inside the window
  task automatic noteChk(input logic [2:0] k, input logic [CW-1:0] d);
    repeat (12) @(posedge clock);
    chk("notices", 32'h1, nk.size());
    if (nk.size() > 0) begin
      chk("noticeKind", {29'h0, k}, {29'h0, nk[0]});
      chk("noticeData", d, nd[0]);
    end
    nk.delete();
    nd.delete();
  endtask : noteChk
  function automatic logic [NCNT-1:0] classify(input int len, input int kind);
    logic [NCNT-1:0] m;
    m = '0;
    if (len > MAX_FRAME_BYTES) m[C_OVER] = 1'b1;
    else if (len >= MIN_FRAME_BYTES) m[kind == 0 ? C_GOOD : (kind == 1 ? C_CRC : C_ALIGN)] = 1'b1;
    return m;
  endfunction : classify
  task automatic frame(input int p, input int len, input int kind);
    logic [NCNT-1:0] m;
    m = classify(len, kind);
    @(posedge clock);
    frameEnd[p]   <= 1'b1;
    frameLen      <= len[10:0];
    crcOk[p]      <= (kind == 0);
    framingErr[p] <= (kind == 2);
    @(posedge clock);
    frameEnd[p] <= 1'b0;
    for (int c = 0; c < NCNT; c++) if (m[c]) expCnt[p][c]++;
    if (m[C_GOOD]) expCnt[p][C_OCTET] += len;
  endtask : frame
  // carrier held len cycles, 4-cycle collisions at c1 and c2
  task automatic burst(input int p, input int len, input int c1, input int c2);
    for (int i = 0; i < len; i++) begin
      @(posedge clock);
      carrierPin[p]   <= 1'b1;
      collisionPin[p] <= (i >= c1 && i < c1 + 4) || (i >= c2 && i < c2 + 4);
    end
    @(posedge clock);
    carrierPin[p]   <= 1'b0;
    collisionPin[p] <= 1'b0;
    repeat (60) @(posedge clock);
  endtask : burst
  initial begin
    int lens [4];
    int len;
    int k;
    lens = '{63, 64, 1518, 1519};
    reset_n = 1'b0; carrierPin = '0; collisionPin = '0; txActivePin = '0; rateMismatchPin = '0;
    // port 1 starts disabled but partitioned: enable state must win
    partitionedPin = 4'b0011; portPresentPin = 4'hf; groupPresentPin = 1'b1; repeaterTxColl = 1'b0;
    frameEnd = '0; crcOk = '0; framingErr = '0; frameLen = '0; healthIn = HEALTH_OK; enableStore = 4'b0101;
    err_total = 0; samples_checked = 0; cyc = 0;
    foreach (expCnt[p, c]) expCnt[p][c] = '0;
    void'($urandom(32'hc9cd2c45));
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    noteChk(3'd2, HEALTH_OK);
    rdChk("group_identifier", A_GROUP_IDENTIFIER, 32'h0000_0003);
    rdChk("portLimit", A_PORTLIMIT, 32'h0000_0004);
    rdChk("port_presence_bits", A_PORT_PRESENCE_BITS, 32'h0000_000f);
    rdChk("groupMap", A_GROUPMAP, 32'h0000_0001);
    rdChk("unmapped", 8'h90, 32'h0000_0000);
    chk("portEnable", {28'h0, enableStore}, {28'h0, portEnable});
    for (int p = 0; p < NPORTS; p++) begin
      rdChk("enable", {p[3:0], I_ENABLE}, enableStore[p] ? ADMIN_ENABLED : ADMIN_DISABLED);
      rdChk("isolation", {p[3:0], I_ISOLATION}, (enableStore[p] && partitionedPin[p]) ? PART_YES : PART_NO);
    end
    u_agent.portCtl(1, 1'b1);
    #1 chk("restart", 32'h1, {31'h0, isolationRestart[1]});
    @(posedge clock);
    #1 chk("restartEnd", 32'h0, {31'h0, isolationRestart[1]});
    u_agent.portCtl(0, 1'b1);
    #1 chk("noRestart", 32'h0, {31'h0, isolationRestart[0]});
    u_agent.portCtl(1, 1'b0);
    u_agent.portCtl(5, 1'b0);
    #1 chk("portEnable", 32'h5, {28'h0, portEnable});
    rdChk("enable1", {4'h1, I_ENABLE}, ADMIN_DISABLED);
    u_agent.portCtl(1, 1'b1);
    u_agent.portCtl(3, 1'b1);
    #1 chk("portEnable", 32'hf, {28'h0, portEnable});
    for (int i = 0; i < 60; i++) begin
      len = (i < 4) ? lens[i] : $urandom_range(1600, 40);
      k = (len < MIN_FRAME_BYTES || len > MAX_FRAME_BYTES) ? 0 : $urandom_range(2, 0);
      frame($urandom_range(3, 0), len, k);
    end
    burst(2, 50, -10, -10);
    burst(2, 3000, -10, -10);
    burst(2, 7000, 100, 6700);
    expCnt[2][C_BRIEF] = 32'h1;
    expCnt[2][C_RUNT] = 32'h1;
    expCnt[2][C_COLL] = 32'h2;
    expCnt[2][C_LATE] = 32'h1;
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      repeaterTxColl <= (i % 2 == 0);
      rateMismatchPin[3] <= (i % 2 == 0);
      repeat (4) @(posedge clock);
    end
    expCnt[3][C_RATE] = 32'h5;
    repeat (6) @(posedge clock);
    rdChk("txColl", A_TXCOLL, 32'h5);
    @(posedge clock);
    healthIn <= 32'h0000_0005;
    noteChk(3'd1, 32'h0000_0005);
    u_agent.wr(A_ACTION, {28'h0, ACT_SELFTEST});
    noteChk(3'd1, 32'h0000_0005);
    u_agent.wr(A_ACTION, {28'h0, ACT_RESET});
    noteChk(3'd2, 32'h0000_0005);
    chk("portEnable", 32'hf, {28'h0, portEnable});
    groupPresentPin <= 1'b0;
    noteChk(3'd4 - 3'd1, 32'h0000_0000);
    portPresentPin <= 4'hb;
    noteChk(3'd4, 32'h0000_000b);
    rdChk("port_presence_bits", A_PORT_PRESENCE_BITS, 32'h0000_000b);
    // jabber limit too long to reach here; count must stay zero
    for (int p = 0; p < NPORTS; p++) begin
      for (int c = 0; c < NCNT; c++) begin
        rdChk("counter", {p[3:0], c[3:0]}, expCnt[p][c]);
      end
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
